// ==== src/part_timer.sv ====
/*
  Auto-reload PWM timer: prescaler, 8-bit counter, four PWM
  channels, two capture channels and a classic Wishbone slave.
  Assumes pins are synchronous to ref_clk and that the halt mode
  input comes from the power controller.
*/
// Behaviour
// - Counter advances on each prescaler tick.
// - Overflow reloads counter, prescaler untouched.
// - Overflow is FFh to reload value.
// - Counter readable and writable while running.
// - Prescaler divides by two to the select.
// - Clock select chooses CPU or pin clock.
// - Enable low freezes prescaler and counter.
// - Reset clears counter, prescaler, clock select.
// - Force reload (written with enable set) or counter write clears prescaler.
// - Force reload bit reads as zero.
// - Compare shadows load from duty at overflow.
// - Output enable makes pin a PWM driver.
// - Shared period is 256 minus reload.
// - Overflow sets level, match restores it.
// - High at or below compare, polarity inverts.
// - PWM halts in halt mode.
// - Overflow sets flag and optional interrupt.
// - Reading control/status clears overflow flag.
// - Events counted equal 256 minus reload, times two to the select.
// - Two captures latch counter on pin edge.
// - Edge select, interrupt enable, capture flag.
// - Captures blocked until value is read.
// - Capture interrupt follows flag and enable.
// - Timer events can wake the processor.
`timescale 1ns/10ps

module part_timer
  import part_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire part_wb_req_t wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic extClockInput,
  input wire logic haltMode,
  input wire logic [CAPTURES-1:0] captureInPin,
  output logic [CHANNELS-1:0] pwmOutPin,
  output logic [CHANNELS-1:0] pwmOutPinOe,
  output logic overflowIrq,
  output logic [CAPTURES-1:0] captureIrq,
  output logic wakeUp
);

  // ----------------------------------------------------------------
  // Decoding helper
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [5:0] a,
                               input logic [5:0] o);
    hit = (a[5:2] == o[5:2]);
  endfunction : hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  part_ctrl_t ctrl_r;
  logic ovf_r;
  logic [7:0] cnt_r, cnt_nxt;
  logic [6:0] presc_r, presc_nxt;
  logic [7:0] arr_r;
  logic [3:0] oe_r, pol_r;
  logic [7:0] duty_r [CHANNELS];
  logic [7:0] shadow_r [CHANNELS];
  logic [CHANNELS-1:0] pwmLvl_r;
  logic [CAPTURES-1:0] edgeSel_r, capIe_r, capFlag_r, capPrev_r;
  logic [7:0] capVal_r [CAPTURES];
  logic extPrev_r;
  logic ack_r;
  logic [31:0] datO_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = wbReq.cyc & wbReq.stb;
  wire wbWr = req & ack_r & wbReq.we & wbReq.sel[0];
  wire wbRd = req & ack_r & ~wbReq.we;
  wire [7:0] wd = wbReq.dat[7:0];
  wire csrWr = wbWr & hit(wbReq.adr, `PART_OFS_CSR);
  wire csrRd = wbRd & hit(wbReq.adr, `PART_OFS_CSR);
  wire carWr = wbWr & hit(wbReq.adr, `PART_OFS_CAR);
  wire fcrlHit = csrWr & wd[`PART_CSR_FORCE_RELOAD] & wd[`PART_CSR_TCE];

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  // Halt stops every count: the CPU clock is gone and the pin clock
  // is not guaranteed, so nothing may creep forward meanwhile.
  wire extRise = extClockInput & ~extPrev_r;
  wire inTick = ctrl_r.extClockSelect ? extRise : 1'b1;
  wire run = ctrl_r.countEnableBit & ~haltMode;
  wire [6:0] tapMask = 7'(8'h01 << ctrl_r.prescaleSelect) - 7'h01;
  wire tapHit = (presc_r & tapMask) == tapMask;
  wire cntTick = run & inTick & tapHit;
  wire ovfEvt = cntTick & (cnt_r == `PART_CNT_MAX);
  wire busLoad = carWr | fcrlHit;

  always_comb begin
    cnt_nxt = cnt_r;
    if (carWr) begin
      cnt_nxt = wd;
    end else if (fcrlHit || ovfEvt) begin
      cnt_nxt = arr_r;
    end else if (cntTick) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_comb begin
    presc_nxt = presc_r;
    if (busLoad) begin
      presc_nxt = 7'h00;
    end else if (run && inTick) begin
      presc_nxt = presc_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= `PART_RST_BYTE;
      presc_r <= 7'h00;
      extPrev_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      presc_r <= presc_nxt;
      extPrev_r <= extClockInput;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= '0;
      arr_r <= `PART_RST_BYTE;
      oe_r <= 4'h0;
      pol_r <= 4'h0;
      edgeSel_r <= '0;
      capIe_r <= '0;
    end else if (wbWr) begin
      if (hit(wbReq.adr, `PART_OFS_CSR)) begin
        ctrl_r <= {wd[`PART_CSR_EXT_CLOCK_SELECT],
                   wd[`PART_CSR_CCHI:`PART_CSR_CCLO],
                   wd[`PART_CSR_TCE], wd[`PART_CSR_OIE]};
      end
      if (hit(wbReq.adr, `PART_OFS_ARR)) begin
        arr_r <= wd;
      end
      if (hit(wbReq.adr, `PART_OFS_PCR)) begin
        oe_r <= wd[7:4];
        pol_r <= wd[3:0];
      end
      if (hit(wbReq.adr, `PART_OFS_CCS)) begin
        edgeSel_r <= wd[`PART_CCS_EDGE +: CAPTURES];
        capIe_r <= wd[`PART_CCS_IE +: CAPTURES];
      end
    end
  end

  // A new overflow in the same cycle as the clearing read wins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ovf_r <= 1'b0;
    end else if (ovfEvt) begin
      ovf_r <= 1'b1;
    end else if (csrRd) begin
      ovf_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gPwm
      wire dutyWr = wbWr & hit(wbReq.adr, 6'(`PART_OFS_DC0 + 4 * g));
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          duty_r[g] <= `PART_RST_BYTE;
          shadow_r[g] <= `PART_RST_BYTE;
          pwmLvl_r[g] <= 1'b0;
        end else begin
          if (dutyWr) begin
            duty_r[g] <= wd;
          end
          if (ovfEvt) begin
            shadow_r[g] <= duty_r[g];
          end
          if (!haltMode) begin
            pwmLvl_r[g] <= (cnt_r <= shadow_r[g]);
          end
        end
      end
      // Polarity flips the pin at once, without waiting for a tick.
      assign pwmOutPin[g] = oe_r[g] & (pwmLvl_r[g] ^ pol_r[g]);
      assign pwmOutPinOe[g] = oe_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < CAPTURES; g++) begin : gCap
      wire rise = captureInPin[g] & ~capPrev_r[g];
      wire fall = ~captureInPin[g] & capPrev_r[g];
      wire edgeHit = edgeSel_r[g] ? rise : fall;
      wire valRd = wbRd & hit(wbReq.adr, 6'(`PART_OFS_CV0 + 4 * g));
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          capPrev_r[g] <= 1'b0;
          capFlag_r[g] <= 1'b0;
          capVal_r[g] <= `PART_RST_BYTE;
        end else begin
          capPrev_r[g] <= captureInPin[g];
          if (edgeHit && (!capFlag_r[g] || valRd)) begin
            capVal_r[g] <= cnt_r;
            capFlag_r[g] <= 1'b1;
          end else if (valRd) begin
            capFlag_r[g] <= 1'b0;
          end
        end
      end
      assign captureIrq[g] = capFlag_r[g] & capIe_r[g];
    end
  endgenerate

  assign overflowIrq = ovf_r & ctrl_r.overflowIrqOn;
  assign wakeUp = overflowIrq | (|captureIrq);

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  // Unmapped words read as zero and are still acknowledged, so a
  // stray access never hangs the bus.
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (hit(wbReq.adr, `PART_OFS_CSR)) begin
      rdByte = {ctrl_r.extClockSelect, ctrl_r.prescaleSelect,
                ctrl_r.countEnableBit, 1'b0,
                ctrl_r.overflowIrqOn, ovf_r};
    end
    if (hit(wbReq.adr, `PART_OFS_CAR)) begin
      rdByte = cnt_r;
    end
    if (hit(wbReq.adr, `PART_OFS_ARR)) begin
      rdByte = arr_r;
    end
    if (hit(wbReq.adr, `PART_OFS_PCR)) begin
      rdByte = {oe_r, pol_r};
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (hit(wbReq.adr, 6'(`PART_OFS_DC0 + 4 * i))) begin
        rdByte = duty_r[i];
      end
    end
    if (hit(wbReq.adr, `PART_OFS_CCS)) begin
      rdByte = 8'({edgeSel_r, capIe_r, capFlag_r});
    end
    for (int i = 0; i < CAPTURES; i++) begin
      if (hit(wbReq.adr, 6'(`PART_OFS_CV0 + 4 * i))) begin
        rdByte = capVal_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      datO_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        datO_r <= {24'h00_0000, rdByte};
      end
    end
  end

  assign wbAck = ack_r;
  assign wbDatO = datO_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_count;
    cntTick && !busLoad && cnt_r != 8'hff |=>
      cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("count step");

  property p_reload;
    ovfEvt && !busLoad |=> cnt_r == $past(arr_r) &&
      presc_r == 7'($past(presc_r) + 7'h01);
  endproperty
  a_reload: assert property (p_reload) else $error("reload");

  property p_extHold;
    ctrl_r.extClockSelect && !(extClockInput && !extPrev_r) &&
      !busLoad |=> $stable(cnt_r);
  endproperty
  a_extHold: assert property (p_extHold) else $error("ext hold");

  property p_freeze;
    !ctrl_r.countEnableBit && !busLoad |=>
      $stable(cnt_r) && $stable(presc_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze");

  property p_force;
    fcrlHit |=> cnt_r == $past(arr_r) && presc_r == 7'h00;
  endproperty
  a_force: assert property (p_force) else $error("force reload");

  property p_shadow;
    ovfEvt |=> shadow_r[0] == $past(duty_r[0]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow");

  property p_pwmLevel;
    !haltMode |=> pwmLvl_r[0] == ($past(cnt_r) <= $past(shadow_r[0]));
  endproperty
  a_pwmLevel: assert property (p_pwmLevel) else $error("pwm level");

  property p_pwmHalt;
    haltMode |=> $stable(pwmLvl_r);
  endproperty
  a_pwmHalt: assert property (p_pwmHalt) else $error("pwm halt");

  property p_ovfSet;
    ovfEvt |=> ovf_r;
  endproperty
  a_ovfSet: assert property (p_ovfSet) else $error("ovf set");

  property p_ovfClr;
    csrRd && !ovfEvt |=> !ovf_r;
  endproperty
  a_ovfClr: assert property (p_ovfClr) else $error("ovf clear");

  property p_capLatch;
    captureInPin[0] != capPrev_r[0] && captureInPin[0] == edgeSel_r[0] &&
      !capFlag_r[0] |=> capVal_r[0] == $past(cnt_r) && capFlag_r[0];
  endproperty
  a_capLatch: assert property (p_capLatch) else $error("capture");

  property p_capHold;
    capFlag_r[0] && !(wbRd && hit(wbReq.adr, `PART_OFS_CV0)) |=>
      $stable(capVal_r[0]) && capFlag_r[0];
  endproperty
  a_capHold: assert property (p_capHold) else $error("capture held");

  property p_capIrq;
    capFlag_r[0] && capIe_r[0] |-> captureIrq[0] && wakeUp;
  endproperty
  a_capIrq: assert property (p_capIrq) else $error("capture irq");

  property p_ack;
    wbAck |=> !wbAck;
  endproperty
  a_ack: assert property (p_ack) else $error("ack pulse");

endmodule : part_timer

// ==== src/part_params.svh ====
/*
  Constants of the auto-reload PWM timer: register byte offsets,
  field positions and reset values.
  Assumes it is included by bare name before the package.
*/
`ifndef PART_PARAMS_SVH
`define PART_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PART_OFS_CSR 6'h00
`define PART_OFS_CAR 6'h04
`define PART_OFS_ARR 6'h08
`define PART_OFS_PCR 6'h0c
`define PART_OFS_DC0 6'h10
`define PART_OFS_CCS 6'h20
`define PART_OFS_CV0 6'h24

// ----------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------
`define PART_CSR_EXT_CLOCK_SELECT 7
`define PART_CSR_CCHI 6
`define PART_CSR_CCLO 4
`define PART_CSR_TCE 3
`define PART_CSR_FORCE_RELOAD 2
`define PART_CSR_OIE 1
`define PART_CSR_OVF 0

// ----------------------------------------------------------------
// Capture control/status fields
// ----------------------------------------------------------------
`define PART_CCS_EDGE 4
`define PART_CCS_IE 2
`define PART_CCS_FLAG 0

// ----------------------------------------------------------------
// Reset value and counter maximum
// ----------------------------------------------------------------
`define PART_RST_BYTE 8'h00
`define PART_CNT_MAX 8'hff

`endif

// ==== src/part_pkg.sv ====
/*
  Types of the auto-reload PWM timer.
  Assumes the parameter header is on the include path.
*/
`include "part_params.svh"

package part_pkg;

  // ----------------------------------------------------------------
  // Wishbone request as driven by the master
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] dat;
  } part_wb_req_t;

  // ----------------------------------------------------------------
  // Control/status register fields, bit 7 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic extClockSelect;
    logic [2:0] prescaleSelect;
    logic countEnableBit;
    logic overflowIrqOn;
  } part_ctrl_t;

endpackage : part_pkg

// ==== verification/part_far_side.sv ====
/*
  Far-side model: external event source, capture pins, PWM loads.
  Assumes the bench calls its tasks just after a ref_clk edge.
*/
`timescale 1ns/10ps
module part_far_side (
  input wire logic ref_clk,
  input wire logic [3:0] pwmOutPin,
  output logic extClk,
  output logic [1:0] capPin
);
  int highCnt [4];

  initial begin
    extClk = 1'b0;
    capPin = 2'b00;
  end

  // The event pin rests low between events; gap sets slow or prompt.
  task automatic pulse_ext(input int n, input int gap);
    repeat (n) begin
      @(posedge ref_clk);
      extClk <= 1'b1;
      repeat (gap) @(posedge ref_clk);
      extClk <= 1'b0;
      repeat (gap) @(posedge ref_clk);
    end
  endtask : pulse_ext

  task automatic set_cap(input int ch, input logic lvl);
    @(posedge ref_clk);
    capPin[ch] <= lvl;
  endtask : set_cap

  // Any window of one whole period gives the same high count.
  task automatic measure(input int n);
    for (int i = 0; i < 4; i++) highCnt[i] = 0;
    repeat (n) begin
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        if (pwmOutPin[i] === 1'b1) highCnt[i]++;
      end
    end
  endtask : measure
endmodule : part_far_side

// ==== verification/tb_part_timer.sv ====
/*
  Self-checking bench of the auto-reload PWM timer.
  Assumes the package, its header and the far-side model come first.
*/
`timescale 1ns/10ps
`include "part_params.svh"
module tb_part_timer
  import part_pkg::*;
;
  logic ref_clk, resetn, haltMode, extClk, ack, ovIrq, wake, e, ie;
  logic [1:0] capPin, capIrq;
  logic [3:0] pwm, pwmOe, oe, pol;
  logic [31:0] datO, q;
  logic [7:0] arr, v, dat;
  logic [7:0] d [4];
  part_wb_req_t req;
  int miscompares, checksDone, seed, t1;
  int cycN = 0;

  part_timer dut (
    .ref_clk(ref_clk), .resetn(resetn), .wbReq(req), .wbDatO(datO),
    .wbAck(ack), .extClockInput(extClk), .haltMode(haltMode),
    .captureInPin(capPin), .pwmOutPin(pwm), .pwmOutPinOe(pwmOe),
    .overflowIrq(ovIrq), .captureIrq(capIrq), .wakeUp(wake)
  );
  part_far_side far (
    .ref_clk(ref_clk), .pwmOutPin(pwm), .extClk(extClk), .capPin(capPin)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cycN <= cycN + 1;

  function automatic int pwm_hi(logic [7:0] dd, logic p, logic o);
    return !o ? 0 : p ? 255 - int'(dd) : int'(dd) + 1;
  endfunction : pwm_hi

  task automatic give_verdict();
    if (miscompares == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request holds until ack is sampled high; data is taken there.
  task automatic wb(input logic we, input logic [5:0] a,
                    input logic [7:0] dd, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, 4'h1, a, {24'h0, dd}};
    @(posedge ref_clk);
    while (ack !== 1'b1) begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        miscompares++;
        give_verdict();
      end
    end
    r = datO;
    req <= '0;
    @(posedge ref_clk);
  endtask : wb

  task automatic wait_ov();
    int n;
    n = 0;
    while (ovIrq !== 1'b1) begin
      @(posedge ref_clk);
      n++;
      if (n > 20000) begin
        miscompares++;
        give_verdict();
      end
    end
  endtask : wait_ov

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hd97b;
    resetn = 1'b0;
    haltMode = 1'b0;
    req = '0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a < 12; a++) begin
      wb(1'b0, 6'(a * 4), 8'h00, q);
      chk(q, 32'h0);
    end
    wb(1'b1, `PART_OFS_ARR, 8'h80, q);
    wb(1'b1, `PART_OFS_CSR, 8'h7c, q);
    wb(1'b0, `PART_OFS_CAR, 8'h00, q);
    chk(q, 32'h80);
    // Without the prescaler clear a tick would land inside the read.
    repeat (121) @(posedge ref_clk);
    wb(1'b1, `PART_OFS_CAR, 8'h20, q);
    wb(1'b0, `PART_OFS_CAR, 8'h00, q);
    chk(q, 32'h20);
    wb(1'b1, `PART_OFS_CSR, 8'h70, q);
    wb(1'b0, `PART_OFS_CAR, 8'h00, q);
    v = q[7:0];
    repeat (300) @(posedge ref_clk);
    wb(1'b0, `PART_OFS_CAR, 8'h00, q);
    chk(q, {24'h0, v});
    for (int ps = 0; ps < 8; ps++) begin
      arr = 8'hc0 | (8'($random(seed)) & 8'h1f);
      dat = {1'b0, 3'(ps), 4'b1110};
      wb(1'b1, `PART_OFS_ARR, arr, q);
      wb(1'b1, `PART_OFS_CSR, dat, q);
      wb(1'b0, `PART_OFS_CSR, 8'h00, q);
      chk(q & 32'hfe, {24'h0, dat[7:3], 1'b0, dat[1], 1'b0});
      wait_ov();
      t1 = cycN;
      wb(1'b0, `PART_OFS_CSR, 8'h00, q);
      chk(q, {24'h0, dat[7:3], 1'b0, dat[1], 1'b1});
      chk({31'h0, ovIrq}, 32'h0);
      wait_ov();
      chk(32'(cycN - t1), 32'((256 - int'(arr)) << ps));
    end
    wb(1'b1, `PART_OFS_ARR, 8'hfd, q);
    wb(1'b1, `PART_OFS_CSR, 8'h8e, q);
    wb(1'b0, `PART_OFS_CSR, 8'h00, q);
    far.pulse_ext(2, 1 + int'($random(seed) & 3));
    repeat (4) @(posedge ref_clk);
    chk({31'h0, ovIrq}, 32'h0);
    far.pulse_ext(1, 1 + int'($random(seed) & 3));
    repeat (4) @(posedge ref_clk);
    chk({31'h0, ovIrq}, 32'h1);
    chk({31'h0, wake}, 32'h1);
    wb(1'b1, `PART_OFS_ARR, 8'h00, q);
    wb(1'b1, `PART_OFS_CSR, 8'h0c, q);
    repeat (2) begin
      {oe, pol} = 8'($random(seed)) | 8'h10;
      for (int i = 0; i < 4; i++) begin
        d[i] = 8'($random(seed));
        if (d[i] == 8'h00) d[i] = 8'hff;
        wb(1'b1, 6'(`PART_OFS_DC0 + 4 * i), d[i], q);
      end
      wb(1'b1, `PART_OFS_PCR, {oe, pol}, q);
      repeat (300) @(posedge ref_clk);
      far.measure(256);
      chk({28'h0, pwmOe}, {28'h0, oe});
      for (int i = 0; i < 4; i++) begin
        chk(32'(far.highCnt[i]), 32'(pwm_hi(d[i], pol[i], oe[i])));
      end
    end
    wb(1'b1, `PART_OFS_CSR, 8'h00, q);
    // The counter is stopped, so only a bus write can move the level.
    wb(1'b1, `PART_OFS_CAR, 8'h00, q);
    haltMode <= 1'b1;
    wb(1'b1, `PART_OFS_CAR, 8'hff, q);
    repeat (2) @(posedge ref_clk);
    chk({28'h0, pwm}, {28'h0, oe & ~pol});
    haltMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      chk(32'(pwm[i]), 32'(oe[i] & ((d[i] == 8'hff) ^ pol[i])));
    end
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 2; k++) begin
        e = k[0];
        ie = 1'($random(seed));
        v = 8'($random(seed));
        dat = 8'h00;
        dat[4 + ch] = e;
        dat[2 + ch] = ie;
        wb(1'b1, `PART_OFS_CAR, v, q);
        wb(1'b1, `PART_OFS_CCS, dat, q);
        far.set_cap(ch, ~e);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, capIrq[ch]}, 32'h0);
        far.set_cap(ch, e);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, capIrq[ch]}, {31'h0, ie});
        chk({31'h0, wake}, {31'h0, ie});
        wb(1'b0, `PART_OFS_CCS, 8'h00, q);
        chk(q, 32'(dat | (1 << ch)));
        wb(1'b1, `PART_OFS_CAR, ~v, q);
        far.set_cap(ch, ~e);
        far.set_cap(ch, e);
        repeat (4) @(posedge ref_clk);
        wb(1'b0, 6'(`PART_OFS_CV0 + 4 * ch), 8'h00, q);
        chk(q, {24'h0, v});
        wb(1'b0, `PART_OFS_CCS, 8'h00, q);
        chk(q, {24'h0, dat});
      end
    end
    give_verdict();
  end
endmodule : tb_part_timer
